// file: include/start_seq_pkg.sv
// Constants for the two-instance bus start/restart sequencer.
// Assumes a 100 MHz system clock; no module logic lives here.
package start_seq_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] RELOAD0_OFF = 4'h0;
  localparam logic [3:0] RELOAD1_OFF = 4'h1;
  localparam logic [3:0] CTRL0_OFF = 4'h2;
  localparam logic [3:0] CTRL1_OFF = 4'h3;
  localparam logic [3:0] STATUS0_OFF = 4'h4;
  localparam logic [3:0] STATUS1_OFF = 4'h5;
  localparam logic [3:0] TXBUF0_OFF = 4'h6;
  localparam logic [3:0] TXBUF1_OFF = 4'h7;
  // Control field positions
  localparam int START_BIT = 0;
  localparam int RESTART_BIT = 1;
  localparam int CTRL_LOCK_BITS = 5;
  // Status field positions
  localparam int START_SEEN_BIT = 3;
  localparam int IRQ_BIT = 4;
  localparam int BCOL_BIT = 5;
  localparam int WRITE_COLLISION_FLAG_BIT = 6;
  // Reset values
  localparam logic [7:0] RELOAD_RST = 8'h18;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Ticks: two counter decrements per instruction cycle of four sys clocks
  localparam int TICK_DIV = 2;
  localparam logic [7:0] READ_NONE = 8'h00;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_S_WAIT, ST_S_HOLD, ST_R_LOW, ST_R_SDA, ST_R_SCLW,
    ST_R_HIGH, ST_R_FALL
  } seq_state_e;
endpackage : start_seq_pkg

// file: verilog/start_seq_core.sv
// Two bus master start/restart sequencers with rate counters and a
// register port. Assumes open-drain bus lines resolved outside.
`timescale 1ns/100ps
`default_nettype none

// One channel: rate counter plus start/restart sequencer
module start_seq_chan (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic tick_i,
  input wire logic [7:0] reload_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic start_set_i,
  input wire logic restart_set_i,
  input wire logic txbuf_wr_i,
  input wire logic [7:0] txbuf_data_i,
  input wire logic clr_flags_i,
  input wire logic [7:0] clr_mask_i,
  output logic start_request,
  output logic restart_request,
  output logic [7:0] status,
  output logic [7:0] transmit_buffer,
  output logic scl_low,
  output logic sda_low
);
  start_seq_pkg::seq_state_e state;
  logic [6:0] rate_counter;
  logic start_seen, serial_irq_flag, bus_collision_flag;
  logic write_collision_flag;
  logic busy, expired, col_ev, done_ev, start_phase;
  logic scl_q;

  assign busy = (state != start_seq_pkg::ST_IDLE);
  assign expired = (rate_counter == 7'h00);
  // Own data drive held low with the clock high: the Start itself
  assign start_phase = (state == start_seq_pkg::ST_S_HOLD) ||
                       (state == start_seq_pkg::ST_R_FALL);

  // Rate counter: decrements on tick, stops at zero (R22)
  // Reloads per state step; each channel owns its reload (R1) (R2) (R3)
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_counter <= 7'h00;
    end else if (state == start_seq_pkg::ST_IDLE && start_request &&
                 scl_i && sda_i) begin
      rate_counter <= reload_i[6:0]; // R7
    end else if (state == start_seq_pkg::ST_S_WAIT && expired && tick_i &&
                 scl_i && sda_i) begin
      rate_counter <= reload_i[6:0]; // R9
    end else if (state == start_seq_pkg::ST_R_LOW && !scl_i) begin
      rate_counter <= {1'b0, reload_i[5:0]}; // R14
    end else if (state == start_seq_pkg::ST_R_SCLW && scl_i) begin
      rate_counter <= reload_i[6:0]; // R5 R6 R15
    end else if (state == start_seq_pkg::ST_R_HIGH && expired && tick_i) begin
      rate_counter <= reload_i[6:0]; // R16
    end else if (tick_i && !expired && state != start_seq_pkg::ST_R_SCLW) begin
      rate_counter <= rate_counter - 7'h01; // R5 paused while SCL released
    end
  end

  // Sequencer; collisions abort to idle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= start_seq_pkg::ST_IDLE;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      unique case (state)
        start_seq_pkg::ST_IDLE: begin
          if (start_request) begin
            if (scl_i && sda_i) begin
              state <= start_seq_pkg::ST_S_WAIT; // R7
              sda_low <= 1'b0;
            end
          end else if (restart_request) begin
            state <= start_seq_pkg::ST_R_LOW;
            scl_low <= 1'b1; // R13
          end
        end
        start_seq_pkg::ST_S_WAIT: begin
          if (!scl_i) begin
            state <= start_seq_pkg::ST_IDLE; // R10
          end else if (expired && tick_i && sda_i) begin
            sda_low <= 1'b1; // R8
            state <= start_seq_pkg::ST_S_HOLD;
          end
        end
        start_seq_pkg::ST_S_HOLD: begin
          if (expired && tick_i) begin
            state <= start_seq_pkg::ST_IDLE; // R9 keeps SDA low
          end
        end
        start_seq_pkg::ST_R_LOW: begin
          if (!scl_i) begin
            sda_low <= 1'b0; // R14
            state <= start_seq_pkg::ST_R_SDA;
          end
        end
        start_seq_pkg::ST_R_SDA: begin
          if (expired && tick_i && sda_i) begin
            scl_low <= 1'b0; // R15
            state <= start_seq_pkg::ST_R_SCLW;
          end
        end
        start_seq_pkg::ST_R_SCLW: begin
          if (scl_i) begin
            if (!sda_i) begin
              state <= start_seq_pkg::ST_IDLE; // R19
            end else begin
              state <= start_seq_pkg::ST_R_HIGH;
            end
          end
        end
        start_seq_pkg::ST_R_HIGH: begin
          if (!scl_i) begin
            state <= start_seq_pkg::ST_IDLE; // R19
          end else if (expired && tick_i) begin
            sda_low <= 1'b1; // R16
            state <= start_seq_pkg::ST_R_FALL;
          end
        end
        start_seq_pkg::ST_R_FALL: begin
          if (expired && tick_i) begin
            state <= start_seq_pkg::ST_IDLE; // R16 no reload
          end
        end
      endcase
    end
  end

  // Collision causes: start with both low, SDA low at SCL rise, or SCL falls early (R10) (R19)
  assign col_ev =
    (state == start_seq_pkg::ST_IDLE && start_request && !scl_i && !sda_i) ||
    (state == start_seq_pkg::ST_S_WAIT && !scl_i) ||
    (state == start_seq_pkg::ST_R_SCLW && scl_i && !sda_i) ||
    (state == start_seq_pkg::ST_R_HIGH && !scl_i);
  assign done_ev = expired && tick_i && start_phase;

  // Request bits: lower five locked while busy, hardware clears at end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_request <= 1'b0;
      restart_request <= 1'b0;
    end else begin
      if (state == start_seq_pkg::ST_S_HOLD && done_ev) begin
        start_request <= 1'b0; // R9
      end else if (col_ev && start_request) begin
        start_request <= 1'b0; // R10
      end else if (start_set_i && !busy && !restart_request) begin
        start_request <= 1'b1; // R12
      end
      if (state == start_seq_pkg::ST_R_FALL && done_ev) begin
        restart_request <= 1'b0; // R16
      end else if (col_ev && restart_request) begin
        restart_request <= 1'b0;
      end else if (restart_set_i && !busy && !start_request) begin
        restart_request <= 1'b1; // R12 R18
      end
    end
  end

  // Status flags: hardware set wins over software clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_seen <= 1'b0;
      serial_irq_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
      write_collision_flag <= 1'b0;
    end else begin
      if (scl_q && scl_i && !sda_i && start_phase) begin
        start_seen <= 1'b1; // R8 R17
      end else if (clr_flags_i && clr_mask_i[start_seq_pkg::START_SEEN_BIT]) begin
        start_seen <= 1'b0;
      end
      if (done_ev) begin
        serial_irq_flag <= 1'b1; // R17
      end else if (clr_flags_i && clr_mask_i[start_seq_pkg::IRQ_BIT]) begin
        serial_irq_flag <= 1'b0;
      end
      if (col_ev) begin
        bus_collision_flag <= 1'b1; // R10 R19
      end else if (clr_flags_i && clr_mask_i[start_seq_pkg::BCOL_BIT]) begin
        bus_collision_flag <= 1'b0;
      end
      if (txbuf_wr_i && busy) begin
        write_collision_flag <= 1'b1; // R11 R20
      end else if (clr_flags_i && clr_mask_i[start_seq_pkg::WRITE_COLLISION_FLAG_BIT]) begin
        write_collision_flag <= 1'b0; // R23 only software clears
      end
    end
  end

  // Previous clock sample; resets to the idle level, so no false Start
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
    end
  end

  // Transmit buffer: writes during a sequence are dropped
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transmit_buffer <= 8'h00;
    end else if (txbuf_wr_i && !busy) begin
      transmit_buffer <= txbuf_data_i; // R11 R20
    end
  end

  assign status = {1'b0, write_collision_flag, bus_collision_flag,
                   serial_irq_flag, start_seen | start_phase,
                   1'b0, restart_request, start_request};

  bus_col_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    col_ev |=> bus_collision_flag && state == start_seq_pkg::ST_IDLE) // R10
    else $error("collision did not flag and abort");
  write_collision_flag_keep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (txbuf_wr_i && busy) |=> write_collision_flag &&
    $stable(transmit_buffer)) // R11
    else $error("buffer write during sequence not refused");
  start_drive_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == start_seq_pkg::ST_S_WAIT && expired && tick_i && scl_i && sda_i)
    |=> sda_low && state == start_seq_pkg::ST_S_HOLD) // R8
    else $error("start edge not driven");
  start_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == start_seq_pkg::ST_S_HOLD && done_ev) |=>
    !start_request && sda_low && serial_irq_flag) // R9
    else $error("start completion wrong");
  pause_cnt_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == start_seq_pkg::ST_R_SCLW && !scl_i) |=> $stable(rate_counter)) // R5
    else $error("counter ran with SCL held low");
  reload_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == start_seq_pkg::ST_R_SCLW && scl_i) |=>
    rate_counter == $past(reload_i[6:0])) // R6
    else $error("no full reload after SCL high");
  rs_low_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == start_seq_pkg::ST_R_LOW && !scl_i) |=>
    rate_counter == {1'b0, $past(reload_i[5:0])} && !sda_low) // R14
    else $error("restart low phase wrong");
  rs_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == start_seq_pkg::ST_R_FALL && done_ev) |=>
    !restart_request && sda_low && serial_irq_flag) // R16
    else $error("restart completion wrong");
  lock_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (busy && !restart_request && restart_set_i) |=> !restart_request) // R18
    else $error("restart accepted while busy");
  cnt_down_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (tick_i && !expired && state == start_seq_pkg::ST_S_HOLD) |=>
    rate_counter == $past(rate_counter) - 7'h01) // R22
    else $error("counter did not decrement");
  start_c: cover property (@(posedge sys_clk_i) done_ev && start_request);
  restart_c: cover property (@(posedge sys_clk_i) done_ev && restart_request);
  coll_c: cover property (@(posedge sys_clk_i) col_ev);
endmodule : start_seq_chan

// Notes on behaviour
// (R1) Each of two channels owns a reload value and rate counter.
// (R2) Both channels count from the shared system clock ticks.
// (R3) One bus clock period equals two full countdowns of the counter.
// (R4) Integrator supplies a fast enough clock for the highest bus rate.
// (R5) Counter pauses while released clock line is not yet sampled high.
// (R6) On clock high, reload from seven low reload bits, count again.
// (R7) Start request with both lines high reloads counter and starts.
// (R8) On expiry with lines high, drive data low and flag start seen.
// (R9) Count once more, then clear start request, keep data low.
// (R10) Start collision flags, aborts and returns to idle.
// (R11) Buffer writes during Start are dropped and flag write collision.
// (R12) Low five control bits ignore writes during a running sequence.
// (R13) Restart request from idle first pulls the clock line low.
// (R14) Clock sampled low: load six reload bits, release data line.
// (R15) Expiry with data high releases clock, then full reload on high.
// (R16) Drive data low one period, clear restart request, no reload.
// (R17) Start seen sets on the lines; interrupt flag after final expiry.
// (R18) Restart request while another event runs has no effect.
// (R19) Restart collision: data low at clock rise, or clock falls early.
// (R20) Buffer writes during Restart are dropped, flag write collision.
// (R21) Software then writes address bytes after the interrupt flag.
// (R22) Counter loads seven bits, decrements twice per instruction cycle.
// (R23) Software alone clears the write collision flag.
// (R24) Bus lines pass synchronisers before any decision uses them.
module start_seq_core #(
  parameter int NUM_CHAN = 2
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [NUM_CHAN-1:0] scl_i,
  input wire logic [NUM_CHAN-1:0] sda_i,
  output logic [NUM_CHAN-1:0] scl_o,
  output logic [NUM_CHAN-1:0] scl_oe_o,
  output logic [NUM_CHAN-1:0] sda_o,
  output logic [NUM_CHAN-1:0] sda_oe_o
);
  logic [1:0] tick_cnt;
  logic tick;
  logic [2:0] scl_sync [NUM_CHAN];
  logic [2:0] sda_sync [NUM_CHAN];
  logic [NUM_CHAN-1:0] scl_f, sda_f;
  logic [7:0] rate_reload_reg [NUM_CHAN];
  logic [7:0] stat_w [NUM_CHAN];
  logic [7:0] buf_w [NUM_CHAN];
  logic [NUM_CHAN-1:0] scl_low_w, sda_low_w;

  // Tick twice per four-clock instruction cycle (R2) (R22)
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= 2'h0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end
  assign tick = tick_cnt[0];

  // Per-channel synchroniser, reload register and sequencer (R1)
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    // Three stages; a level counts when stages two and three agree (R24)
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        scl_sync[c] <= 3'h7;
        sda_sync[c] <= 3'h7;
        scl_f[c] <= 1'b1;
        sda_f[c] <= 1'b1;
      end else begin
        scl_sync[c] <= {scl_sync[c][1:0], scl_i[c]};
        sda_sync[c] <= {sda_sync[c][1:0], sda_i[c]};
        if (scl_sync[c][1] == scl_sync[c][2]) scl_f[c] <= scl_sync[c][2];
        if (sda_sync[c][1] == sda_sync[c][2]) sda_f[c] <= sda_sync[c][2];
      end
    end

    // Reload register steers the channel's rate
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        rate_reload_reg[c] <= start_seq_pkg::RELOAD_RST;
      end else if (wr_i && addr_i == start_seq_pkg::RELOAD0_OFF + 4'(c)) begin
        rate_reload_reg[c] <= wdata_i;
      end
    end

    start_seq_chan u_chan (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .tick_i(tick),
      .reload_i(rate_reload_reg[c]),
      .scl_i(scl_f[c]),
      .sda_i(sda_f[c]),
      .start_set_i(wr_i && addr_i == start_seq_pkg::CTRL0_OFF + 4'(c) &&
                   wdata_i[start_seq_pkg::START_BIT]),
      .restart_set_i(wr_i && addr_i == start_seq_pkg::CTRL0_OFF + 4'(c) &&
                     wdata_i[start_seq_pkg::RESTART_BIT]),
      .txbuf_wr_i(wr_i && addr_i == start_seq_pkg::TXBUF0_OFF + 4'(c)),
      .txbuf_data_i(wdata_i),
      .clr_flags_i(wr_i && addr_i == start_seq_pkg::STATUS0_OFF + 4'(c)),
      .clr_mask_i(wdata_i),
      .start_request(),
      .restart_request(),
      .status(stat_w[c]),
      .transmit_buffer(buf_w[c]),
      .scl_low(scl_low_w[c]),
      .sda_low(sda_low_w[c])
    );

    // Open-drain outputs: drive low only, registered
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        scl_oe_o[c] <= 1'b0;
        sda_oe_o[c] <= 1'b0;
        scl_o[c] <= 1'b0;
        sda_o[c] <= 1'b0;
      end else begin
        scl_oe_o[c] <= scl_low_w[c];
        sda_oe_o[c] <= sda_low_w[c];
        scl_o[c] <= 1'b0;
        sda_o[c] <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= start_seq_pkg::READ_NONE;
    end else if (rd_i) begin
      unique case (addr_i)
        start_seq_pkg::RELOAD0_OFF: rdata_o <= rate_reload_reg[0];
        start_seq_pkg::RELOAD1_OFF: rdata_o <= rate_reload_reg[1];
        start_seq_pkg::CTRL0_OFF: rdata_o <= {6'h00, stat_w[0][1:0]};
        start_seq_pkg::CTRL1_OFF: rdata_o <= {6'h00, stat_w[1][1:0]};
        start_seq_pkg::STATUS0_OFF: rdata_o <= {stat_w[0][7:3], 3'h0};
        start_seq_pkg::STATUS1_OFF: rdata_o <= {stat_w[1][7:3], 3'h0};
        start_seq_pkg::TXBUF0_OFF: rdata_o <= buf_w[0];
        start_seq_pkg::TXBUF1_OFF: rdata_o <= buf_w[1];
        default: rdata_o <= start_seq_pkg::READ_NONE;
      endcase
    end else begin
      rdata_o <= start_seq_pkg::READ_NONE;
    end
  end
endmodule : start_seq_core
`default_nettype wire

// file: dv/peer_bus_model.sv
// Far side of both bus channels: pull-ups, a slow slave and rival masters.
// Assumes device enables are high while the device pulls a line low.
`timescale 1ns/100ps
`default_nettype none
module peer_bus_model #(
  parameter int STRETCH_NS = 485 // Off the clock edge: no race with sampling
) (
  input wire logic [1:0] scl_oe_i,
  input wire logic [1:0] sda_oe_i,
  input wire logic [1:0] stretch_i,
  input wire logic [1:0] hold_scl_i,
  input wire logic [1:0] hold_sda_i,
  output logic [1:0] scl_o,
  output logic [1:0] sda_o
);
  logic [1:0] stretch_low;
  // A slow slave keeps the clock low a while after the master lets go
  for (genvar g = 0; g < 2; g++) begin : g_ch
    initial begin
      stretch_low[g] = 1'b0;
      forever begin
        @(negedge scl_oe_i[g]);
        if (stretch_i[g]) begin
          stretch_low[g] = 1'b1;
          #(STRETCH_NS);
          stretch_low[g] = 1'b0;
        end
      end
    end
  end
  // Pull-up: a released line floats high, any puller wins
  assign scl_o = ~(scl_oe_i | hold_scl_i | stretch_low);
  assign sda_o = ~(sda_oe_i | hold_sda_i);
endmodule : peer_bus_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the start/restart sequencer core.
// Assumes the design package is compiled first; peer model on the bus.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk_i, arst_n_i, wr_i, rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, rd_val;
  logic [1:0] scl_l, sda_l, scl_oe, sda_oe, stretch, hold_scl, hold_sda;
  logic [1:0] scl_dat, sda_dat;
  logic [31:0] seed;
  logic [7:0] m_txbuf [2]; // Expected transmit buffer contents
  int rl [2];              // Reload values in use
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int t0, t1, t2;

  start_seq_core #(.NUM_CHAN(2)) dut_u (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .scl_i(scl_l), .sda_i(sda_l), .scl_o(scl_dat), .scl_oe_o(scl_oe),
    .sda_o(sda_dat), .sda_oe_o(sda_oe));
  peer_bus_model peer_u (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .stretch_i(stretch), .hold_scl_i(hold_scl), .hold_sda_i(hold_sda),
    .scl_o(scl_l), .sda_o(sda_l));

  // 100 MHz, well above the slowest clock a fast bus needs
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Cut a hang short; the run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask : bus_rd

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    bus_rd(a);
    check(rd_val & m, e);
  endtask : rd_chk

  // Poll until the masked value shows, bounded by lim reads
  task automatic poll(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e, input int lim);
    for (int i = 0; i < lim; i++) begin
      bus_rd(a);
      if ((rd_val & m) === e) break;
    end
    check(rd_val & m, e);
  endtask : poll

  // Wait for an enable level; sel 0 clock line, 1 data line
  task automatic wait_oe(input int sel, input int ch, input logic v);
    #1;
    for (int i = 0; i < 400; i++) begin
      if ((sel == 0 ? scl_oe[ch] : sda_oe[ch]) === v) break;
      @(posedge sys_clk_i);
      #1;
    end
  endtask : wait_oe

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    arst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    {stretch, hold_scl, hold_sda} = 6'h00;
    seed = 32'hFBE5A36A;
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    // Reset values, and quiet reads outside the map
    for (int ch = 0; ch < 2; ch++) begin
      rd_chk(start_seq_pkg::RELOAD0_OFF + 4'(ch), 8'h7F, 8'h18);
      rd_chk(start_seq_pkg::CTRL0_OFF + 4'(ch), 8'hFF, 8'h00);
      rd_chk(start_seq_pkg::STATUS0_OFF + 4'(ch), 8'h78, 8'h00);
    end
    for (int a = 8; a < 16; a++) rd_chk(4'(a), 8'hFF, 8'h00);
    // Both channels start together at different rates
    seed = lfsr(seed);
    rl[0] = 3 + int'(seed[1:0]);
    rl[1] = rl[0] + 5;
    for (int ch = 0; ch < 2; ch++) begin
      seed = lfsr(seed);
      m_txbuf[ch] = seed[7:0];
      bus_wr(start_seq_pkg::RELOAD0_OFF + 4'(ch), 8'(rl[ch]));
      bus_wr(start_seq_pkg::TXBUF0_OFF + 4'(ch), m_txbuf[ch]);
    end
    bus_wr(start_seq_pkg::CTRL1_OFF, 8'h01);
    bus_wr(start_seq_pkg::CTRL0_OFF, 8'h01);
    t0 = cycles;
    fork
      begin
        wait_oe(1, 0, 1'b1);
        t1 = cycles - t0;
      end
      begin
        wait_oe(1, 1, 1'b1);
        t2 = cycles - t0;
      end
    join
    check(8'(t1 >= 2 * rl[0] && t1 <= 2 * rl[0] + 12), 8'h01);
    check(8'(t2 >= 2 * rl[1] - 2 && t2 <= 2 * rl[1] + 10), 8'h01);
    // Writes while channel 1 still finishes its start are refused
    seed = lfsr(seed);
    bus_wr(start_seq_pkg::TXBUF1_OFF, seed[7:0]);
    bus_wr(start_seq_pkg::CTRL1_OFF, 8'h02);
    rd_chk(start_seq_pkg::CTRL1_OFF, 8'h03, 8'h01);
    rd_chk(start_seq_pkg::STATUS1_OFF, 8'h18, 8'h08);
    for (int ch = 0; ch < 2; ch++) begin
      poll(start_seq_pkg::STATUS0_OFF + 4'(ch), 8'h18, 8'h18, 40);
      rd_chk(start_seq_pkg::CTRL0_OFF + 4'(ch), 8'h03, 8'h00);
      check({6'h0, scl_oe[ch], sda_oe[ch]}, 8'h01);
      check({6'h0, scl_dat[ch], sda_dat[ch]}, 8'h00);
    end
    rd_chk(start_seq_pkg::STATUS1_OFF, 8'h40, 8'h40);
    rd_chk(start_seq_pkg::TXBUF1_OFF, 8'hFF, m_txbuf[1]);
    rd_chk(start_seq_pkg::STATUS0_OFF, 8'h40, 8'h00);
    bus_wr(start_seq_pkg::STATUS1_OFF, 8'h40);
    rd_chk(start_seq_pkg::STATUS1_OFF, 8'h40, 8'h00);
    seed = lfsr(seed);
    m_txbuf[0] = seed[7:0];
    bus_wr(start_seq_pkg::TXBUF0_OFF, m_txbuf[0]);
    rd_chk(start_seq_pkg::TXBUF0_OFF, 8'hFF, m_txbuf[0]);
    // Restart against a stretching slave; bit 6 and 7 set in the reload
    stretch[0] <= 1'b1;
    bus_wr(start_seq_pkg::RELOAD0_OFF, 8'hC0 | 8'(rl[0]));
    bus_wr(start_seq_pkg::STATUS0_OFF, 8'h78);
    bus_wr(start_seq_pkg::CTRL0_OFF, 8'h02);
    t0 = cycles;
    wait_oe(0, 0, 1'b1);
    check(8'(cycles - t0 <= 6), 8'h01);
    wait_oe(1, 0, 1'b0);
    check(8'(cycles - t0 <= 12), 8'h01);
    t0 = cycles;
    wait_oe(0, 0, 1'b0);
    t1 = cycles - t0;
    check(8'(t1 >= 2 * rl[0] && t1 <= 2 * rl[0] + 12), 8'h01);
    t0 = cycles;
    seed = lfsr(seed);
    bus_wr(start_seq_pkg::TXBUF0_OFF, seed[7:0]);
    bus_wr(start_seq_pkg::CTRL0_OFF, 8'h01);
    rd_chk(start_seq_pkg::CTRL0_OFF, 8'h03, 8'h02);
    wait_oe(1, 0, 1'b1);
    t1 = cycles - t0;
    check(8'(t1 >= 176 + 2 * rl[0] && t1 <= 192 + 2 * rl[0]), 8'h01);
    rd_chk(start_seq_pkg::STATUS0_OFF, 8'h18, 8'h08);
    poll(start_seq_pkg::STATUS0_OFF, 8'h18, 8'h18, 100);
    rd_chk(start_seq_pkg::CTRL0_OFF, 8'h03, 8'h00);
    check({6'h0, scl_oe[0], sda_oe[0]}, 8'h01);
    rd_chk(start_seq_pkg::STATUS0_OFF, 8'h40, 8'h40);
    rd_chk(start_seq_pkg::TXBUF0_OFF, 8'hFF, m_txbuf[0]);
    // Second reset, then rival masters hold the lines
    arst_n_i <= 1'b0;
    stretch <= 2'b00;
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    hold_scl[1] <= 1'b1;
    hold_sda[1] <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    bus_wr(start_seq_pkg::CTRL1_OFF, 8'h01);
    poll(start_seq_pkg::STATUS1_OFF, 8'h20, 8'h20, 10);
    rd_chk(start_seq_pkg::CTRL1_OFF, 8'h03, 8'h00);
    check({7'h0, sda_oe[1]}, 8'h00);
    bus_wr(start_seq_pkg::CTRL0_OFF, 8'h01);
    repeat (10) @(posedge sys_clk_i);
    hold_scl[0] <= 1'b1;
    poll(start_seq_pkg::STATUS0_OFF, 8'h20, 8'h20, 10);
    check({7'h0, sda_oe[0]}, 8'h00);
    // Data held low by a rival as the clock rises during a restart
    {hold_scl, hold_sda} <= 4'h0;
    stretch[1] <= 1'b1;
    bus_wr(start_seq_pkg::STATUS1_OFF, 8'h78);
    bus_wr(start_seq_pkg::CTRL1_OFF, 8'h02);
    wait_oe(0, 1, 1'b1);
    wait_oe(0, 1, 1'b0);
    hold_sda[1] <= 1'b1;
    poll(start_seq_pkg::STATUS1_OFF, 8'h20, 8'h20, 120);
    final_report();
  end
endmodule : testbench
`default_nettype wire
